// ==== dbu_host.sv ====
// host side model: sends and receives 8n1 characters
// assumes bit_cyc is set before the sync character
`timescale 1ns/1ns
`default_nettype none
module dbu_host
(
  // clock
  input wire logic clk,
  // serial lines
  output logic line_out,
  input wire logic line_in
);
  int bit_cyc = 16;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
  endtask
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (line_in !== 1'b0 && n < 9000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (bit_cyc / 2) @(negedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_cyc) @(negedge clk);
      b[i] = line_in;
    end
    repeat (bit_cyc) @(negedge clk);
    ok = line_in === 1'b1 && n < 9000;
  endtask
endmodule
`default_nettype wire

// ==== dbu_link.v ====
// debug uart link: autobaud, command decode, debug register access and burst data
// assumes one clock; rstn is power-on reset; dbg_en is async debug enable
`timescale 1ns/1ns
`default_nettype none
`include "dbu_regs.vh"
module dbu_link
(
  // clock and reset
  input wire clk,
  input wire rstn,
  input wire dbg_en,
  // serial line
  input wire rxd,
  output wire txd,
  // debug register port
  output reg [5:0] reg_addr,
  output reg [15:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd,
  output reg reg_byte,
  input wire [15:0] reg_rdata,
  // burst access to memory side
  output reg [15:0] mem_addr,
  output reg [15:0] mem_wdata,
  output reg mem_wr,
  output reg mem_rd,
  output reg mem_byte,
  output reg mem_cpu_reg,
  input wire [15:0] mem_rdata,
  input wire mem_rvalid,
  input wire [15:0] burst_addr_start,
  input wire [15:0] burst_count_reg,
  // reset request and status
  input wire puc_req_in,
  output reg puc_req,
  output wire synced
);
  localparam S_SYNC = 8'h01;
  localparam S_CMD = 8'h02;
  localparam S_WLO = 8'h04;
  localparam S_WHI = 8'h08;
  localparam S_RSND = 8'h10;
  localparam S_BWR = 8'h20;
  localparam S_BRD = 8'h40;
  localparam S_BSND = 8'h80;

  wire arst_n = rstn & dbg_en;
  wire rx_s;
  reg rx_d;
  reg [7:0] state;
  reg [15:0] bit_cyc;
  reg [15:0] meas;
  reg meas_on;
  reg [15:0] rcnt;
  reg [3:0] rbit;
  reg rx_busy;
  reg [7:0] rsh;
  reg rx_done;
  reg [7:0] cmd;
  reg [15:0] txbuf;
  reg tx_hi;
  reg tx_send;
  reg [7:0] tx_data;
  reg [15:0] bcnt;
  reg bhi;
  wire tx_busy;
  wire cmd_wr = rsh[`DBU_CMD_WR];
  wire cmd_bw = rsh[`DBU_CMD_BW];

  dbu_sync u_sync
  (
    .clk(clk),
    .rstn(arst_n),
    .din(rxd),
    .dout(rx_s)
  );

  dbu_tx u_tx
  (
    .clk(clk),
    .rstn(arst_n),
    .bit_cyc(bit_cyc),
    .send(tx_send),
    .data(tx_data),
    .busy(tx_busy),
    .txd(txd)
  );

  assign synced = (state != S_SYNC);

  // receiver and baud measurement
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_d <= 1'b1;
      bit_cyc <= `DBU_ZERO16;
      meas <= `DBU_ZERO16;
      meas_on <= 1'b0;
      rcnt <= `DBU_ZERO16;
      rbit <= 4'h0;
      rx_busy <= 1'b0;
      rsh <= `DBU_ZERO8;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_d <= rx_s;
      rx_done <= 1'b0;
      if (state == S_SYNC)
      begin
        if (rx_d && !rx_s)
        begin
          meas_on <= 1'b1;
          meas <= `DBU_ONE16;
        end
        else if (meas_on && rx_s)
        begin
          meas_on <= 1'b0;
          bit_cyc <= meas >> `DBU_DIV_SHIFT;
          rx_done <= 1'b1;
        end
        else if (meas_on && meas != 16'hFFFF)
          meas <= meas + `DBU_ONE16;
      end
      else if (!rx_busy)
      begin
        if (rx_d && !rx_s)
        begin
          // first sample at mid start bit
          rx_busy <= 1'b1;
          rbit <= 4'h0;
          rcnt <= bit_cyc >> 1;
        end
      end
      else if (rcnt == `DBU_ZERO16)
      begin
        rcnt <= bit_cyc - `DBU_ONE16;
        rbit <= rbit + 4'h1;
        if (rbit == 4'h0 && rx_s)
          rx_busy <= 1'b0;
        else if (rbit == `DBU_BITS + 4'h1)
        begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
        end
        else if (rbit != 4'h0)
          rsh <= {rx_s, rsh[7:1]};
      end
      else
        rcnt <= rcnt - `DBU_ONE16;
    end
  end

  // command decode and burst engine
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= S_SYNC;
      cmd <= `DBU_ZERO8;
      reg_addr <= 6'h00;
      reg_wdata <= `DBU_ZERO16;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_byte <= 1'b0;
      mem_addr <= `DBU_ZERO16;
      mem_wdata <= `DBU_ZERO16;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      mem_byte <= 1'b0;
      mem_cpu_reg <= 1'b0;
      txbuf <= `DBU_ZERO16;
      tx_hi <= 1'b0;
      tx_send <= 1'b0;
      tx_data <= `DBU_ZERO8;
      bcnt <= `DBU_ZERO16;
      bhi <= 1'b0;
      puc_req <= 1'b0;
    end
    else
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      tx_send <= 1'b0;
      puc_req <= puc_req_in;
      case (state)
        S_SYNC:
        begin
          if (rx_done)
            state <= S_CMD;
        end
        S_CMD:
        begin
          if (rx_done)
          begin
            cmd <= rsh;
            reg_addr <= rsh[5:0];
            reg_byte <= cmd_bw;
            if (cmd_wr)
              state <= S_WLO;
            else
            begin
              reg_rd <= 1'b1;
              state <= S_RSND;
              tx_hi <= 1'b0;
            end
          end
        end
        S_WLO:
        begin
          if (rx_done)
          begin
            reg_wdata <= {`DBU_ZERO8, rsh};
            // byte write goes straight to the burst check
            if (cmd[`DBU_CMD_BW])
              reg_wr <= 1'b1;
            state <= S_WHI;
          end
        end
        S_WHI:
        begin
          if (reg_wr)
          begin
            if (cmd[5:0] == `DBU_MCTL_ADDR && reg_wdata[`DBU_MCTL_START]
                && burst_count_reg != `DBU_ZERO16)
            begin
              // burst starts right after start bit
              mem_addr <= burst_addr_start;
              bcnt <= burst_count_reg;
              mem_byte <= reg_wdata[`DBU_MCTL_BW];
              mem_cpu_reg <= reg_wdata[`DBU_MCTL_REG];
              bhi <= 1'b0;
              state <= reg_wdata[`DBU_MCTL_WR] ? S_BWR : S_BRD;
              if (!reg_wdata[`DBU_MCTL_WR])
                mem_rd <= 1'b1;
            end
            else
              state <= S_CMD;
          end
          else if (rx_done)
          begin
            reg_wdata <= {rsh, reg_wdata[7:0]};
            reg_wr <= 1'b1;
          end
        end
        S_RSND:
        begin
          if (!tx_busy && !tx_send && !reg_rd)
          begin
            tx_send <= 1'b1;
            tx_data <= tx_hi ? txbuf[15:8] : reg_rdata[7:0];
            if (!tx_hi)
              txbuf <= reg_rdata;
            if (tx_hi || cmd[`DBU_CMD_BW])
              state <= S_CMD;
            tx_hi <= 1'b1;
          end
        end
        S_BWR:
        begin
          if (rx_done)
          begin
            mem_wdata <= bhi ? {rsh, mem_wdata[7:0]} : {8'h00, rsh};
            bhi <= !bhi && !mem_byte;
            if (bhi || mem_byte)
              mem_wr <= 1'b1;
          end
          if (mem_wr)
          begin
            mem_addr <= mem_addr + (mem_byte ? `DBU_ONE16 : `DBU_TWO16);
            bcnt <= bcnt - `DBU_ONE16;
            if (bcnt == `DBU_ONE16)
              state <= S_CMD;
          end
        end
        S_BRD:
        begin
          if (mem_rvalid)
          begin
            txbuf <= mem_rdata;
            tx_hi <= 1'b0;
            state <= S_BSND;
          end
        end
        S_BSND:
        begin
          if (!tx_busy && !tx_send)
          begin
            tx_send <= 1'b1;
            tx_data <= tx_hi ? txbuf[15:8] : txbuf[7:0];
            tx_hi <= 1'b1;
            if (tx_hi || mem_byte)
            begin
              mem_addr <= mem_addr + (mem_byte ? `DBU_ONE16 : `DBU_TWO16);
              bcnt <= bcnt - `DBU_ONE16;
              if (bcnt == `DBU_ONE16)
                state <= S_CMD;
              else
              begin
                mem_rd <= 1'b1;
                state <= S_BRD;
              end
            end
          end
        end
        default:
          state <= S_SYNC;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dbu_link_bench.sv ====
// bench for the debug uart link: host model, register and memory responders
// assumes 10 MHz clock and a 16 cycle bit period, 24 cycles for the resync test
`timescale 1ns/1ns
`default_nettype none
module dbu_link_bench;
  logic clk, rstn, dbg_en, rxd, txd, reg_wr, reg_rd, reg_byte, mem_wr, mem_rd;
  logic mem_byte, mem_cpu_reg, mem_rvalid, puc_req_in, puc_req, synced;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] burst_addr_start, burst_count_reg;
  logic [32:0] wq[$], aq[$], mq[$];
  logic [32:0] w;
  int errors, n_compared;
  localparam logic [15:0] RV = 16'hB64D;
  dbu_link uut (.clk(clk), .rstn(rstn), .dbg_en(dbg_en), .rxd(rxd), .txd(txd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_byte(reg_byte), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_byte(mem_byte),
    .mem_cpu_reg(mem_cpu_reg), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .burst_addr_start(burst_addr_start), .burst_count_reg(burst_count_reg),
    .puc_req_in(puc_req_in), .puc_req(puc_req), .synced(synced));
  dbu_host host (.clk(clk), .line_out(rxd), .line_in(txd));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // responders and access log
  always @(posedge clk)
  begin
    reg_rdata <= reg_rd ? RV : ~RV;
    mem_rvalid <= mem_rd;
    mem_rdata <= mem_rd ? mem_addr ^ RV : 16'h0000;
    if (reg_wr) wq.push_back({10'h0, reg_byte, reg_addr, reg_wdata});
    if (reg_rd) aq.push_back({27'h0, reg_addr});
    if (mem_wr || mem_rd) mq.push_back({mem_wr, mem_addr, mem_wdata});
  end
  function automatic logic [32:0] take(ref logic [32:0] q[$]);
    return q.size() ? q.pop_front() : 'x;
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rx(input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    host.recv(b, ok);
    chk({ok, b}, {1'b1, exp});
  endtask
  task automatic rd_cmd(input logic [7:0] cmd, input logic [15:0] exp);
    @(posedge clk);
    fork
      host.send(cmd);
      begin
        chk_rx(exp[7:0]);
        if (!cmd[6]) chk_rx(exp[15:8]);
      end
    join
    chk(take(aq), cmd[5:0]);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    final_report;
  end
  initial
  begin
    errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    dbg_en = 1'b1;
    puc_req_in = 1'b0;
    burst_addr_start = 16'h0200;
    burst_count_reg = 16'h0002;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (40) @(posedge clk);
    chk({txd, synced}, 2'b10);
    host.send(8'h80);
    repeat (4) @(posedge clk);
    chk(synced, 1'b1);
    $display("test sync done");
    host.send(8'h85);
    host.send(8'h34);
    host.send(8'h12);
    host.send(8'hC3);
    host.send(8'hA5);
    repeat (16) @(posedge clk);
    chk(take(wq), {10'h0, 7'h05, 16'h1234});
    w = take(wq);
    chk({w[22:16], w[7:0]}, {7'h43, 8'hA5});
    rd_cmd(8'h05, RV);
    rd_cmd(8'h43, RV);
    $display("test register access done");
    host.send(8'hC4);
    host.send(8'h03);
    host.send(8'h11);
    host.send(8'h22);
    host.send(8'h33);
    host.send(8'h44);
    repeat (16) @(posedge clk);
    w = take(wq);
    chk({w[22:16], w[7:0]}, {7'h44, 8'h03});
    chk(take(mq), {1'b1, 16'h0200, 16'h2211});
    chk(take(mq), {1'b1, 16'h0202, 16'h4433});
    fork
      begin
        host.send(8'hC4);
        host.send(8'h05);
      end
      begin
        chk_rx(RV[7:0] ^ 8'h00);
        chk_rx(RV[15:8] ^ 8'h02);
        chk_rx(RV[7:0] ^ 8'h02);
        chk_rx(RV[15:8] ^ 8'h02);
      end
    join
    w = take(wq);
    chk({w[22:16], w[7:0]}, {7'h44, 8'h05});
    chk({mem_byte, mem_cpu_reg}, 2'b01);
    chk(take(mq) >> 16, {1'b0, 16'h0200});
    chk(take(mq) >> 16, {1'b0, 16'h0202});
    @(posedge clk);
    burst_addr_start <= 16'h0311;
    burst_count_reg <= 16'h0003;
    fork
      begin
        host.send(8'hC4);
        host.send(8'h09);
      end
      begin
        chk_rx(RV[7:0] ^ 8'h11);
        chk_rx(RV[7:0] ^ 8'h12);
        chk_rx(RV[7:0] ^ 8'h13);
      end
    join
    w = take(wq);
    chk({w[22:16], w[7:0]}, {7'h44, 8'h09});
    chk({mem_byte, mem_cpu_reg}, 2'b10);
    chk(take(mq) >> 16, {1'b0, 16'h0311});
    chk(take(mq) >> 16, {1'b0, 16'h0312});
    chk(take(mq) >> 16, {1'b0, 16'h0313});
    @(posedge clk);
    burst_count_reg <= 16'h0000;
    host.send(8'hC4);
    host.send(8'h03);
    rd_cmd(8'h43, RV);
    w = take(wq);
    chk({w[22:16], w[7:0]}, {7'h44, 8'h03});
    $display("test bursts done");
    @(posedge clk);
    puc_req_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk(puc_req, 1'b1);
    puc_req_in <= 1'b0;
    dbg_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk({txd, synced, puc_req}, 3'b100);
    dbg_en <= 1'b1;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    host.bit_cyc = 24;
    host.send(8'h80);
    rd_cmd(8'h07, RV);
    $display("test resync done");
    chk(wq.size() + aq.size() + mq.size(), 0);
    final_report;
  end
endmodule
`default_nettype wire

// ==== dbu_link_props.sv ====
// checker for the debug uart link: sync gating, pulses, answer timing
// assumes bind to dbu_link; reset is rstn and dbg_en together
`timescale 1ns/1ns
`default_nettype none
module dbu_link_props
(
  // clock and resets
  input wire logic clk,
  input wire logic rstn,
  input wire logic dbg_en,
  // watched signals
  input wire logic txd,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_rvalid,
  input wire logic puc_req_in,
  input wire logic puc_req,
  input wire logic synced
);
  default clocking @(posedge clk); endclocking
  default disable iff (!(rstn && dbg_en));
  sequence s_start_bit;
    !txd [*6];
  endsequence
  sequence s_one_pulse;
    !(reg_wr && reg_rd) ##1 !(reg_wr || reg_rd);
  endsequence
  AST_IDLE_BEFORE_SYNC: assert property (!synced |-> txd)
    else $error("txd not idle before sync");
  AST_NO_DECODE: assert property (!synced |-> !(reg_wr || reg_rd || mem_wr || mem_rd))
    else $error("access before sync");
  AST_SYNC_KEPT: assert property (synced |=> synced)
    else $error("bit period lost");
  AST_START_BIT_LEN: assert property ($fell(txd) |-> s_start_bit)
    else $error("start bit too short");
  AST_READ_ANSWER: assert property (reg_rd |-> ##[1:20] !txd)
    else $error("no answer to read");
  AST_REG_PULSE: assert property ((reg_wr || reg_rd) |-> s_one_pulse)
    else $error("register strobe shape");
  AST_BURST_DIRECT: assert property ((mem_wr || mem_rd) |-> !(reg_wr || reg_rd))
    else $error("burst used register port");
  AST_BURST_SEND: assert property (mem_rvalid |-> ##[1:400] !txd)
    else $error("burst data not sent");
  AST_PUC_FOLLOW: assert property ($rose(puc_req_in) |-> ##[1:2] puc_req)
    else $error("reset request lost");
endmodule
bind dbu_link dbu_link_props u_props (.clk(clk), .rstn(rstn), .dbg_en(dbg_en),
  .txd(txd), .reg_wr(reg_wr), .reg_rd(reg_rd), .mem_wr(mem_wr), .mem_rd(mem_rd),
  .mem_rvalid(mem_rvalid), .puc_req_in(puc_req_in), .puc_req(puc_req), .synced(synced));
`default_nettype wire

// ==== dbu_regs.vh ====
// debug uart link: constants for frame layout, command bits and memory control
// assumes inclusion by bare name from the design files
`ifndef DBU_REGS_VH
`define DBU_REGS_VH

`define DBU_SYNC_CHAR 8'h80
`define DBU_CMD_WR 7
`define DBU_CMD_BW 6
`define DBU_ADDR_W 6
`define DBU_MCTL_ADDR 6'h04
`define DBU_MADDR_ADDR 6'h05
`define DBU_MDATA_ADDR 6'h06
`define DBU_MCNT_ADDR 6'h07
`define DBU_MCTL_START 0
`define DBU_MCTL_WR 1
`define DBU_MCTL_REG 2
`define DBU_MCTL_BW 3
`define DBU_BITS 4'h8
`define DBU_FRAME_STEPS 4'hB
`define DBU_DIV_SHIFT 3
`define DBU_CNT_W 16
`define DBU_CLK_HZ 10000000
`define DBU_MAX_BPS 1500000
`define DBU_MIN_BIT_CYC (`DBU_CLK_HZ / `DBU_MAX_BPS)
`define DBU_ZERO16 16'h0000
`define DBU_ZERO8 8'h00
`define DBU_ONE16 16'h0001
`define DBU_TWO16 16'h0002

`endif

// ==== dbu_sync.v ====
// debug uart link: two-flop synchroniser for the receive line
// assumes the line idles high, so reset value is high
`timescale 1ns/1ns
`default_nettype none
module dbu_sync
(
  // clock and reset
  input wire clk,
  input wire rstn,
  // async in, synced out
  input wire din,
  output reg dout
);
  reg meta;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== dbu_tx.v ====
// debug uart link: 8n1 transmitter, lsb first, idles high
// assumes bit period in clk cycles is nonzero and stable during a frame
`timescale 1ns/1ns
`default_nettype none
`include "dbu_regs.vh"
module dbu_tx
(
  // clock and reset
  input wire clk,
  input wire rstn,
  // bit period
  input wire [15:0] bit_cyc,
  // byte request
  input wire send,
  input wire [7:0] data,
  output wire busy,
  // serial line
  output reg txd
);
  reg [9:0] shreg;
  reg [3:0] left;
  reg [15:0] cnt;
  assign busy = (left != 4'h0);
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shreg <= 10'h3FF;
      left <= 4'h0;
      cnt <= `DBU_ZERO16;
      txd <= 1'b1;
    end
    else if (!busy)
    begin
      txd <= 1'b1;
      if (send)
      begin
        shreg <= {1'b1, data, 1'b0};
        // one step past the stop bit so it stands a full period
        left <= `DBU_FRAME_STEPS;
        cnt <= `DBU_ZERO16;
      end
    end
    else if (cnt == `DBU_ZERO16)
    begin
      txd <= shreg[0];
      shreg <= {1'b1, shreg[9:1]};
      cnt <= bit_cyc - `DBU_ONE16;
      left <= left - 4'h1;
    end
    else
      cnt <= cnt - `DBU_ONE16;
  end
endmodule
`default_nettype wire
